// [sop_array_device.sv]
/*
  Sum-of-products array device: pin synchronisers, array line routing,
  the AND array, eight output macrocells, their flip-flops and the
  registered pin drivers.
  Assumes configuration ports are steady and on the sys_clk_i domain;
  all device pins, including the clock pin, are asynchronous to it.
*/
`include "sop_consts.svh"

// Notes on behaviour
// R1: 16 complementary lines cross 64 product terms
// R2: Cell attaches true or inverted line phase
// R3: Term true only when attached lines high
// R4: Eight groups; seven or eight ORed, one enables
// R5: Cell routes combinatorially or through rising-edge flop
// R6: Polarity selectable, applied before the flop
// R7: Three global modes restrict cell choices
// R8: Small mode outputs always drive, no enable
// R9: Registered cells feed flop state back
// R10: Bidirectional combinatorial cells in registered, medium modes
// R11: Medium mode outer cells: three-state outputs
// R12: A cell may serve as pure input
// R13: Combinatorial modes: clock, enable pins are inputs
// R14: Registered mode: one shared clock pin
// R15: Registered mode: common enable for registered outputs
// R16: Small, registered modes: per-cell choice
// R17: Medium mode: single fixed arrangement
// R18: Flops clear low at power-up
// R19: Cleared active-low outputs show high when enabled
// R20: Board holds clock steady until clear ends
// R21: Unattached input toggling leaves outputs unchanged
// R22: Enable pin low enables, high floats
// R23: Term-enabled outputs drive while term true
module sop_array_device #(
  parameter int num_cells = `SOP_CELLS,
  parameter int terms_per_cell = `SOP_TERMS_PER_CELL
) (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire sop_pkg::mode_type mode_i,
  input wire logic [num_cells*terms_per_cell*4*num_cells-1:0] fuse_map_i,
  input wire logic [num_cells-1:0] cell_sel_i,
  input wire logic [num_cells-1:0] cell_pol_high_i,
  input wire logic [num_cells-1:0] dedicated_i,
  input wire logic clk_pin_i,
  input wire logic oe_pin_b_i,
  input wire logic [num_cells-1:0] io_pin_i,
  output logic [num_cells-1:0] io_pin_o,
  output logic [num_cells-1:0] io_pin_oe_o,
  output logic [num_cells-1:0] reg_state_o
);
  import sop_pkg::*;

  localparam int num_lines = 2 * num_cells;
  localparam int num_terms = num_cells * terms_per_cell;

  generate
    if (num_cells < 2 || terms_per_cell < 2)
    begin : g_bad_size
      $error("Need at least two cells and two terms per cell");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stages feed only their second stages

  logic [num_cells-1:0] ded_meta_ff;
  logic [num_cells-1:0] ded_sync_ff;
  logic [num_cells-1:0] pin_meta_ff;
  logic [num_cells-1:0] pin_sync_ff;
  logic clk_meta_ff;
  logic clk_sync_ff;
  logic clk_prev_ff;
  logic oe_meta_ff;
  logic oe_sync_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      ded_meta_ff <= '0;
      ded_sync_ff <= '0;
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end
    else
    begin
      ded_meta_ff <= dedicated_i;
      ded_sync_ff <= ded_meta_ff;
      pin_meta_ff <= io_pin_i;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Clock pin is sampled, not used as a clock: its edges must be slower
  // than a few sys_clk_i periods to be seen
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      clk_meta_ff <= 1'b0;
      clk_sync_ff <= 1'b0;
      clk_prev_ff <= 1'b0;
    end
    else
    begin
      clk_meta_ff <= clk_pin_i;
      clk_sync_ff <= clk_meta_ff;
      clk_prev_ff <= clk_sync_ff;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      oe_meta_ff <= `SOP_OE_IDLE;
      oe_sync_ff <= `SOP_OE_IDLE;
    end
    else
    begin
      oe_meta_ff <= oe_pin_b_i;
      oe_sync_ff <= oe_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Array lines: dedicated inputs, then one feedback line per cell

  logic [num_lines-1:0] lines_w;
  logic [num_cells-1:0] fb_w;
  logic [num_terms-1:0] terms_w;
  logic is_reg_mode_w;
  logic clk_rise_w;

  assign is_reg_mode_w = (mode_i == registered_mode); // R7
  assign clk_rise_w = is_reg_mode_w && clk_sync_ff && !clk_prev_ff; // R14

  always_comb
  begin
    lines_w[num_cells-1:0] = ded_sync_ff;
    lines_w[num_lines-1:num_cells] = fb_w; // R9
    if (!is_reg_mode_w)
    begin
      // Outer cells give up their feedback to the two spare pins
      lines_w[num_cells] = clk_sync_ff; // R13
      lines_w[num_lines-1] = oe_sync_ff; // R13
    end
  end

  product_term_array #(
    .num_lines(num_lines),
    .num_terms(num_terms)
  ) u_array (
    .lines_i(lines_w),
    .fuse_map_i(fuse_map_i),
    .terms_o(terms_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // Macrocells

  logic [num_cells-1:0] q_ff;
  logic [num_cells-1:0] d_w;
  logic [num_cells-1:0] drive_w;
  logic [num_cells-1:0] drive_en_w;
  logic [num_cells-1:0] reg_cells_w;
  logic [num_cells-1:0] en_terms_w;
  logic [num_cells-1:0] rest_val_w;
  logic [2*num_lines-1:0] cols_chk_w;

  genvar k;
  generate
    for (k = 0; k < num_cells; k++)
    begin : g_cell
      output_macrocell #(
        .terms_per_cell(terms_per_cell)
      ) u_cell (
        .mode_i(mode_i),
        .sel_i(cell_sel_i[k]),
        .pol_high_i(cell_pol_high_i[k]),
        .oe_active_i(~oe_sync_ff),
        .terms_i(terms_w[k*terms_per_cell +: terms_per_cell]),
        .q_i(q_ff[k]),
        .pin_i(pin_sync_ff[k]),
        .d_o(d_w[k]),
        .drive_o(drive_w[k]),
        .drive_en_o(drive_en_w[k]),
        .registered_o(reg_cells_w[k]),
        .feedback_o(fb_w[k])
      );
      // Checking aids only
      assign en_terms_w[k] = terms_w[k*terms_per_cell + `SOP_ENABLE_TERM];
      assign rest_val_w[k] = cell_pol_high_i[k] ~^
        (|terms_w[k*terms_per_cell + 1 +: terms_per_cell - 1]);
      assign cols_chk_w[2*k +: 2] = {~lines_w[k], lines_w[k]};
      assign cols_chk_w[2*(k+num_cells) +: 2] = {~lines_w[k+num_cells], lines_w[k+num_cells]};
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Macrocell flip-flops; the only reset is the power-up clear

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      q_ff <= {num_cells{`SOP_CELL_CLEAR}}; // R18
    end
    else if (clk_rise_w)
    begin
      q_ff <= (d_w & reg_cells_w) | (q_ff & ~reg_cells_w); // R5 R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin drivers, one sys_clk_i cycle behind the array

  logic [num_cells-1:0] io_out_ff;
  logic [num_cells-1:0] io_oe_ff;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_b_i)
    begin
      io_out_ff <= '0;
      io_oe_ff <= '0;
    end
    else
    begin
      io_out_ff <= drive_w; // R19
      io_oe_ff <= drive_en_w; // R15 R23
    end
  end

  assign io_pin_o = io_out_ff;
  assign io_pin_oe_o = io_oe_ff;
  assign reg_state_o = q_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_clk_edge;
    clk_rise_w;
  endsequence

  sequence s_captured;
    ((q_ff ^ $past(d_w)) & $past(reg_cells_w)) == '0;
  endsequence

  property p_term_and;
    terms_w[0] == ((fuse_map_i[2*num_lines-1:0] & ~cols_chk_w) == '0);
  endproperty
  a_term_and: assert property (p_term_and) else $error("Term true with low line"); // R3

  property p_capture;
    s_clk_edge |=> s_captured;
  endproperty
  a_capture: assert property (p_capture) else $error("Flop missed capture"); // R5

  property p_shared_clock;
    !clk_rise_w |=> q_ff == $past(q_ff);
  endproperty
  a_shared_clock: assert property (p_shared_clock) else $error("Flop moved without clock"); // R14

  property p_small_drive;
    (mode_i == small_combinatorial_mode) |=> io_pin_oe_o == $past(cell_sel_i);
  endproperty
  a_small_drive: assert property (p_small_drive) else $error("Small mode enable wrong"); // R8

  property p_input_off;
    (mode_i == small_combinatorial_mode && cell_sel_i[0] == 1'b0) |=> !io_pin_oe_o[0];
  endproperty
  a_input_off: assert property (p_input_off) else $error("Input cell drives"); // R12

  property p_common_oe;
    is_reg_mode_w |=> ((io_pin_oe_o ^ {num_cells{~$past(oe_sync_ff)}}) & $past(reg_cells_w)) == '0;
  endproperty
  a_common_oe: assert property (p_common_oe) else $error("Common enable ignored"); // R15

  property p_feedback;
    is_reg_mode_w |-> ((lines_w[num_lines-1:num_cells] ^ ~q_ff) & reg_cells_w) == '0;
  endproperty
  a_feedback: assert property (p_feedback) else $error("Register feedback wrong"); // R9

  property p_spare_pins;
    !is_reg_mode_w |-> lines_w[num_cells] == clk_sync_ff && lines_w[num_lines-1] == oe_sync_ff;
  endproperty
  a_spare_pins: assert property (p_spare_pins) else $error("Spare pins not on array"); // R13

  property p_clear;
    $rose(rst_b_i) |-> q_ff == '0 ##1 (!is_reg_mode_w || (~io_pin_o & reg_cells_w & ~q_ff) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("Power-up clear wrong"); // R18

  property p_clear_high;
    is_reg_mode_w |=> (~io_pin_o & $past(reg_cells_w & ~q_ff)) == '0;
  endproperty
  a_clear_high: assert property (p_clear_high) else $error("Cleared output not high"); // R19

  property p_medium_fixed;
    (mode_i == medium_combinatorial_mode) |=> io_pin_oe_o == $past(en_terms_w);
  endproperty
  a_medium_fixed: assert property (p_medium_fixed) else $error("Medium enable wrong"); // R17

  property p_outer_value;
    (mode_i == medium_combinatorial_mode) |=>
      io_pin_o[0] == $past(rest_val_w[0]) && io_pin_o[num_cells-1] == $past(rest_val_w[num_cells-1]);
  endproperty
  a_outer_value: assert property (p_outer_value) else $error("Outer output wrong"); // R11

  property p_term_enable;
    is_reg_mode_w |=> ((io_pin_oe_o ^ $past(en_terms_w)) & $past(~cell_sel_i)) == '0;
  endproperty
  a_term_enable: assert property (p_term_enable) else $error("Term enable wrong"); // R23

endmodule

// [sop_consts.svh]
/*
  Constants for the sum-of-products array device: array geometry,
  term positions inside a macrocell group and flip-flop clear values.
  Assumes it is included by its bare name from the device, array and macrocell files.
*/
`ifndef SOP_CONSTS_SVH
`define SOP_CONSTS_SVH

// Array geometry
`define SOP_CELLS 8
`define SOP_TERMS_PER_CELL 8

// Term of each group that may serve as the three-state enable
`define SOP_ENABLE_TERM 0

// Power-up value of every macrocell flip-flop
`define SOP_CELL_CLEAR 1'b0

// Idle level of the active-low common enable pin stages
`define SOP_OE_IDLE 1'b1

`endif

// [sop_pkg.sv]
/*
  Types shared by the sum-of-products array device and its macrocells.
  Assumes nothing of its surroundings.
*/
package sop_pkg;

  typedef enum logic [1:0] {
    small_combinatorial_mode,
    registered_mode,
    medium_combinatorial_mode
  } mode_type;

endpackage

// [product_term_array.sv]
/*
  Programmable AND array: each product term ANDs the array lines that
  its connection cells attach, in true or inverted phase.
  Assumes the connection map is a steady configuration input.
*/
`include "sop_consts.svh"

module product_term_array #(
  parameter int num_lines = 2 * `SOP_CELLS,
  parameter int num_terms = `SOP_CELLS * `SOP_TERMS_PER_CELL
) (
  input wire logic [num_lines-1:0] lines_i,
  input wire logic [num_terms*2*num_lines-1:0] fuse_map_i,
  output logic [num_terms-1:0] terms_o
);

  localparam int num_cols = 2 * num_lines;

  logic [num_cols-1:0] cols_w;

  ////////////////////////////////////////////////////////////////////////
  // Each line offers both phases to every term
  genvar j;
  generate
    for (j = 0; j < num_lines; j++)
    begin : g_col
      assign cols_w[2*j] = lines_i[j]; // R2
      assign cols_w[2*j+1] = ~lines_i[j]; // R2
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // One connection cell per crossing; an unattached column cannot pull
  // the term low, so toggling it changes nothing downstream
  genvar t;
  generate
    for (t = 0; t < num_terms; t++)
    begin : g_term
      assign terms_o[t] = &(~fuse_map_i[t*num_cols +: num_cols] | cols_w); // R1 R3 R21
    end
  endgenerate

endmodule

// [output_macrocell.sv]
/*
  One output macrocell: picks registered or combinatorial routing,
  output polarity and the enable source from the global mode.
  Assumes the flip-flop itself and the pin stages live in the parent.
*/
`include "sop_consts.svh"

module output_macrocell #(
  parameter int terms_per_cell = `SOP_TERMS_PER_CELL
) (
  input wire sop_pkg::mode_type mode_i,
  input wire logic sel_i,
  input wire logic pol_high_i,
  input wire logic oe_active_i,
  input wire logic [terms_per_cell-1:0] terms_i,
  input wire logic q_i,
  input wire logic pin_i,
  output logic d_o,
  output logic drive_o,
  output logic drive_en_o,
  output logic registered_o,
  output logic feedback_o
);
  import sop_pkg::*;

  logic sum_all_w;
  logic sum_rest_w;
  logic en_term_w;

  assign sum_all_w = |terms_i; // R4
  assign sum_rest_w = |(terms_i & ~(terms_per_cell'(1) << `SOP_ENABLE_TERM)); // R4
  assign en_term_w = terms_i[`SOP_ENABLE_TERM]; // R4

  // Inverted ahead of the flip-flop; the pin buffer inverts again, so a
  // cleared flip-flop shows high at the pin whatever the polarity
  assign d_o = pol_high_i ? ~sum_all_w : sum_all_w; // R6 R19

  always_comb
  begin
    drive_o = 1'b0;
    drive_en_o = 1'b0;
    registered_o = 1'b0;
    feedback_o = pin_i;
    case (mode_i)
      small_combinatorial_mode:
      begin
        drive_o = pol_high_i ? sum_all_w : ~sum_all_w; // R6
        drive_en_o = sel_i; // R8 R12 R16
      end
      registered_mode:
      begin
        if (sel_i)
        begin
          registered_o = 1'b1; // R5 R16
          drive_o = ~q_i; // R19
          drive_en_o = oe_active_i; // R15
          feedback_o = ~q_i; // R9
        end
        else
        begin
          drive_o = pol_high_i ? sum_rest_w : ~sum_rest_w; // R6
          drive_en_o = en_term_w; // R10 R23
        end
      end
      medium_combinatorial_mode:
      begin
        drive_o = pol_high_i ? sum_rest_w : ~sum_rest_w; // R6 R17
        drive_en_o = en_term_w; // R10 R11 R23
      end
      default:
      begin
        drive_en_o = 1'b0;
      end
    endcase
  end

endmodule

// [sop_board_model.sv]
/*
  Board logic around the sum-of-products array device: drives the clock
  and enable pins and resolves the eight shared pins.
  Assumes the bench changes its requests away from the sampling edge.
*/
module sop_board_model
(
  input wire logic rst_b_i,
  input wire logic clk_req_i,
  input wire logic oe_en_i,
  input wire logic [7:0] board_i,
  input wire logic [7:0] dev_drive_i,
  input wire logic [7:0] dev_oe_i,
  output logic clk_pin_o,
  output logic oe_pin_b_o,
  output logic [7:0] pin_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock pin parked low through the clear, so no false first edge
  assign clk_pin_o = rst_b_i ? clk_req_i : 1'b0;
  assign oe_pin_b_o = ~oe_en_i;
  // Device wins where it drives; elsewhere the board's own driver holds the pin
  assign pin_o = (dev_drive_i & dev_oe_i) | (board_i & ~dev_oe_i);
endmodule

// [sop_array_device_tb.sv]
/*
  Self-checking bench for the sum-of-products array device: random
  configurations in all three modes against an integer model.
  Assumes sop_pkg, the device and the board model are compiled first.
*/
module sop_array_device_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sop_pkg::*;
  logic sys_clk, rst_b, clk_req, oe_en, clk_pin, oe_pin_b;
  mode_type mode;
  logic [2047:0] fuse;
  logic [7:0] sel, pol, ded, board, q, pin, drv, oe, st;
  int num_errors = 0;
  int num_checks = 0;

  sop_array_device uut (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .mode_i(mode), .fuse_map_i(fuse),
    .cell_sel_i(sel), .cell_pol_high_i(pol), .dedicated_i(ded), .clk_pin_i(clk_pin),
    .oe_pin_b_i(oe_pin_b), .io_pin_i(pin), .io_pin_o(drv), .io_pin_oe_o(oe), .reg_state_o(st));
  sop_board_model board_m (.rst_b_i(rst_b), .clk_req_i(clk_req), .oe_en_i(oe_en), .board_i(board),
    .dev_drive_i(drv), .dev_oe_i(oe), .clk_pin_o(clk_pin), .oe_pin_b_o(oe_pin_b), .pin_o(pin));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  function automatic void eval(output logic [7:0] d, output logic [7:0] o, output logic [7:0] e);
    logic [15:0] ln;
    logic [63:0] tm;
    logic or8;
    logic or7;
    ln = {board, ded};
    for (int k = 0; k < 8; k++)
      if (mode == registered_mode && sel[k]) ln[8+k] = ~q[k];
    if (mode != registered_mode)
    begin
      ln[8] = clk_req;
      ln[15] = ~oe_en;
    end
    for (int t = 0; t < 64; t++)
    begin
      tm[t] = 1'b1;
      for (int j = 0; j < 16; j++)
        if ((fuse[t*32+2*j] && !ln[j]) || (fuse[t*32+2*j+1] && ln[j])) tm[t] = 1'b0;
    end
    for (int k = 0; k < 8; k++)
    begin
      or8 = |tm[k*8+:8];
      or7 = |tm[k*8+1+:7];
      d[k] = pol[k] ? ~or8 : or8;
      if (mode == small_combinatorial_mode)
      begin
        e[k] = sel[k];
        o[k] = pol[k] ? or8 : ~or8;
      end
      else if (mode == registered_mode && sel[k])
      begin
        e[k] = oe_en;
        o[k] = ~q[k];
      end
      else
      begin
        e[k] = tm[k*8];
        o[k] = pol[k] ? or7 : ~or7;
      end
    end
  endfunction

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic compare_all();
    logic [7:0] d, o, e;
    eval(d, o, e);
    check(oe, e);
    check(drv & e, o & e);
    check(st, q);
  endtask

  task automatic clk_pulse();
    logic [7:0] d, o, e;
    eval(d, o, e);
    clk_req = 1'b1;
    q = (q & ~sel) | (d & sel);
    wait_cyc(6);
    compare_all();
    clk_req = 1'b0;
    wait_cyc(6);
    compare_all();
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    q = 8'h00;
    wait_cyc(6);
    check(oe, 8'h00);
    check(st, 8'h00);
    rst_b = 1'b1;
    wait_cyc(6);
    compare_all();
  endtask

  // Most terms are killed by both phases of one line, so the sums still toggle
  task automatic shuffle(input mode_type m);
    logic [15:0] al;
    int j;
    mode = m;
    sel = 8'($urandom);
    pol = 8'($urandom);
    ded = 8'($urandom);
    board = 8'($urandom);
    oe_en = 1'($urandom);
    if (m != registered_mode) clk_req = 1'($urandom);
    case (m)
      small_combinatorial_mode: al = {1'b1, ~sel[6:1], 1'b1, 8'hff};
      registered_mode: al = {sel, 8'hff};
      default: al = {1'b1, 6'h00, 1'b1, 8'hff};
    endcase
    for (int t = 0; t < 64; t++)
    begin
      fuse[t*32+:32] = 32'h3;
      if ($urandom % 3 == 0)
      begin
        fuse[t*32+:32] = 32'h0;
        repeat (1 + $urandom % 2)
        begin
          j = $urandom % 16;
          if (al[j]) fuse[t*32+2*j+($urandom%2)] = 1'b1;
        end
      end
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    clk_req = 1'b0;
    oe_en = 1'b1;
    mode = registered_mode;
    fuse = {64{32'h3}};
    sel = 8'hff;
    pol = 8'h00;
    ded = 8'h00;
    board = 8'h00;
    q = 8'h00;
    void'($urandom(32'hae63));
    @(negedge sys_clk);
    do_reset();
    check(drv, 8'hff);
    foreach (q[i]) clk_pulse();
    for (int m = 0; m < 3; m++)
    begin
      clk_req = 1'b0;
      wait_cyc(6);
      // Registered group last, with the clock pin already parked low
      repeat (12)
      begin
        shuffle(m == 0 ? small_combinatorial_mode : m == 1 ? medium_combinatorial_mode : registered_mode);
        wait_cyc(6);
        compare_all();
        if (mode == registered_mode) clk_pulse();
      end
    end
    // Unused mode code must float every pin
    mode = mode_type'(2'h3);
    wait_cyc(6);
    check(oe, 8'h00);
    mode = registered_mode;
    do_reset();
    report_and_stop();
  end

  // Whole run is well under a thousand cycles; this cuts a hang short
  initial
  begin
    #(50 * 6000);
    num_errors++;
    report_and_stop();
  end
endmodule
